/* File: common/rlc_pkg.sv */
// constants and carrier types of the read-out link control register bank
package rlc_pkg;

	// ************************************************************
	// register offsets in base window 0 (byte addresses)
	// ************************************************************
	localparam logic [8:0] OFS_CONTROL_SETUP = 9'h000;
	localparam logic [8:0] OFS_FREE_SEGMENT_FIFO_PORT = 9'h004;
	localparam logic [8:0] OFS_EVENT_PARAM_FIFO_PORT = 9'h008;
	localparam logic [8:0] OFS_SEGMENT_FIFO_CONTROL = 9'h010;
	localparam logic [8:0] OFS_HISTOGRAM_CONTROL = 9'h028;
	localparam logic [8:0] OFS_CROSSING_NUMBER_LINK0 = 9'h040;
	localparam logic [8:0] OFS_CROSSING_NUMBER_LINK1 = 9'h044;
	localparam logic [8:0] OFS_FIRMWARE_REVISION = 9'h048;
	localparam logic [8:0] OFS_SLOW_READ_LOW = 9'h100;
	localparam logic [8:0] OFS_SLOW_READ_HIGH = 9'h104;
	localparam logic [8:0] OFS_SLOW_READ_CTRL = 9'h108;
	localparam logic [8:0] OFS_SLOW_READ_NEXT = 9'h10C;
	localparam logic [8:0] OFS_EVENT_TALLY_LOW = 9'h128;
	localparam logic [8:0] OFS_EVENT_TALLY_HIGH = 9'h12C;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int BIT_IRQ_EMPTY_EN = 8;
	localparam int BIT_IRQ_HALF_EN = 9;
	localparam int BIT_FIFO_NOT_EMPTY = 10;
	localparam int BIT_FIFO_ABOVE_HALF = 11;
	localparam int BIT_SOFT_RESET = 17;
	localparam int BIT_BYTE_SWAP = 19;
	localparam int BIT_SLOW_READ = 22;
	localparam int BIT_LINK_EN_LO = 24;
	localparam int NUM_LINKS = 4;
	localparam int BIT_SPY_ALL = 30;
	localparam int BIT_SPY_EN = 31;
	localparam int BIT_SEG_FIFO_RESET = 16;
	localparam int BIT_SEG_FLUSH = 18;
	localparam int BIT_HIST_CLEAR = 31;
	localparam int BIT_HIST_EN = 30;
	localparam int HIST_GRAN_W = 8;
	localparam int PARAM_FIELD_LO_W = 24;

	// ************************************************************
	// reset values and generator constants
	// ************************************************************
	localparam logic [63:0] EVENT_TALLY_RESET = 64'h0000_0000_0000_0000;
	localparam logic [7:0] HIST_GRAN_RESET = 8'h01;
	localparam logic [7:0] GEN_MULT = 8'h05;
	localparam logic [7:0] GEN_ADD = 8'h03;
	// arbitrary neutral revision value
	localparam logic [31:0] FIRMWARE_REVISION_DEFAULT = 32'h0001_0001;

	// ************************************************************
	// carrier types
	// ************************************************************
	typedef struct packed {
		logic irq_empty_en;
		logic irq_half_en;
		logic byte_swap;
		logic slow_read;
		logic [NUM_LINKS-1:0] link_en;
		logic spy_all;
		logic spy_en;
		logic hist_en;
		logic [HIST_GRAN_W-1:0] hist_gran;
	} rlc_ctrl_type;

	localparam rlc_ctrl_type CTRL_RESET = '{
		irq_empty_en: 1'b0,
		irq_half_en: 1'b0,
		byte_swap: 1'b0,
		slow_read: 1'b0,
		link_en: 4'h0,
		spy_all: 1'b0,
		spy_en: 1'b0,
		hist_en: 1'b0,
		hist_gran: HIST_GRAN_RESET
	};

	typedef struct packed {
		logic [31:0] low;
		logic [31:0] high;
		logic uctrl;
	} rlc_slow_word_type;

endpackage

/* File: rtl/rlc_regs.sv */
// register bank and control logic of the read-out link board
//
// Contract
// - every event passing increments a 64-bit tally; soft reset clears it
// - tally low word returns bits 31..0, high word 63..32; writes ignored
// - control bit 8 enables interrupt while free segment FIFO is empty
// - control bit 9 enables interrupt while free segment FIFO is half empty
// - control bit 10 reads zero when FIFO empty, one when it holds entries
// - control bit 11 reads zero at or below half empty, one otherwise
// - writing one to control bit 17 soft-resets everything but the bus side
// - control bit 19 swaps every byte of event words when set
// - control bit 22 selects slow-read debug mode through the slow-read group
// - control bits 24..27 enable input links 0..3; clear disables
// - control bit 30 spies every event to the host
// - control bit 31 enables spying; spy list loaded beforehand by software
// - segment control bit 16 written one resets the free segment FIFO
// - segment control bit 18 returns all free segments with flagged headers
// - histogram control bit 31 written one clears histogram contents
// - histogram control bit 30 enables word-count accumulation
// - histogram bits 7..0 one-hot bin size, 0x01 smallest, doubling upward
// - two read-only registers give crossing numbers of links 0 and 1
// - parameter words: length/source first, event number/seed second
// - payload byte repeats eight times; next byte is previous times 5 plus 3
`timescale 1ns/1ps

module rlc_regs
	import rlc_pkg::*;
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	// register port from the bus interface
	input wire logic [8:0] REG_ADDR_I,
	input wire logic REG_WR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic REG_RD_I,
	output logic [31:0] REG_RDATA_O,
	output logic REG_RVALID_O,
	// interrupt toward the bus
	output logic INT_O,
	// free segment FIFO status and controls
	input wire logic FREE_FIFO_EMPTY_I,
	input wire logic FREE_FIFO_HALF_I,
	input wire logic FLUSH_DONE_I,
	output logic FREE_SEG_WR_O,
	output logic [31:0] FREE_SEG_DATA_O,
	output logic SEG_FIFO_RESET_O,
	output logic SEG_FLUSH_O,
	// event parameter FIFO write port
	output logic PARAM_WR_O,
	output logic PARAM_SECOND_O,
	output logic [31:0] PARAM_DATA_O,
	// settings, soft reset and histogram clear
	output rlc_ctrl_type CTRL_O,
	output logic SOFT_RESET_O,
	output logic HIST_CLEAR_O,
	// event flow
	input wire logic EVENT_DONE_I,
	input wire logic EVT_VALID_I,
	input wire logic [63:0] EVT_DATA_I,
	output logic EVT_VALID_O,
	output logic [63:0] EVT_DATA_O,
	// payload generator
	input wire logic GEN_LOAD_I,
	input wire logic [7:0] GEN_SEED_I,
	input wire logic GEN_STEP_I,
	output logic [63:0] GEN_WORD_O,
	// link side readback
	input wire logic [31:0] CROSSING0_I,
	input wire logic [31:0] CROSSING1_I,
	input wire rlc_slow_word_type SLOW_WORD_I,
	output logic SLOW_NEXT_O
);

	// ************************************************************
	// decode
	// ************************************************************
	logic wr_control;
	logic wr_free_seg;
	logic wr_param;
	logic wr_seg_ctrl;
	logic wr_hist;
	logic soft_rst;
	logic [63:0] event_tally;
	logic param_second;
	logic [7:0] gen_byte;
	logic [7:0] next_gen_byte;
	logic [31:0] next_rdata;
	logic [63:0] swapped;

	always_comb begin
		wr_control = 1'b0;
		wr_free_seg = 1'b0;
		wr_param = 1'b0;
		wr_seg_ctrl = 1'b0;
		wr_hist = 1'b0;
		if (REG_WR_I && REG_ADDR_I == OFS_CONTROL_SETUP) begin
			wr_control = 1'b1;
		end else if (REG_WR_I && REG_ADDR_I == OFS_FREE_SEGMENT_FIFO_PORT) begin
			wr_free_seg = 1'b1;
		end else if (REG_WR_I && REG_ADDR_I == OFS_EVENT_PARAM_FIFO_PORT) begin
			wr_param = 1'b1;
		end else if (REG_WR_I && REG_ADDR_I == OFS_SEGMENT_FIFO_CONTROL) begin
			wr_seg_ctrl = 1'b1;
		end else if (REG_WR_I && REG_ADDR_I == OFS_HISTOGRAM_CONTROL) begin
			wr_hist = 1'b1;
		end
	end

	// ************************************************************
	// soft reset
	// ************************************************************
	// one-cycle pulse, also clears the local logic on the following edge
	assign soft_rst = SOFT_RESET_O;

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			SOFT_RESET_O <= 1'b0;
		end else begin
			SOFT_RESET_O <= wr_control && REG_WDATA_I[BIT_SOFT_RESET];
		end
	end

	// ************************************************************
	// settings
	// ************************************************************
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			CTRL_O <= CTRL_RESET;
		end else if (soft_rst) begin
			CTRL_O <= CTRL_RESET;
		end else begin
			if (wr_control && !REG_WDATA_I[BIT_SOFT_RESET]) begin
				CTRL_O.irq_empty_en <= REG_WDATA_I[BIT_IRQ_EMPTY_EN];
				CTRL_O.irq_half_en <= REG_WDATA_I[BIT_IRQ_HALF_EN];
				CTRL_O.byte_swap <= REG_WDATA_I[BIT_BYTE_SWAP];
				CTRL_O.slow_read <= REG_WDATA_I[BIT_SLOW_READ];
				CTRL_O.link_en <= REG_WDATA_I[BIT_LINK_EN_LO +: NUM_LINKS];
				CTRL_O.spy_all <= REG_WDATA_I[BIT_SPY_ALL];
				CTRL_O.spy_en <= REG_WDATA_I[BIT_SPY_EN];
			end
			if (wr_hist) begin
				CTRL_O.hist_en <= REG_WDATA_I[BIT_HIST_EN];
				CTRL_O.hist_gran <= REG_WDATA_I[HIST_GRAN_W-1:0];
			end
		end
	end

	// ************************************************************
	// interrupt
	// ************************************************************
	// level output, follows the enabled conditions every cycle
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			INT_O <= 1'b0;
		end else if (soft_rst) begin
			INT_O <= 1'b0;
		end else begin
			INT_O <= (CTRL_O.irq_empty_en && FREE_FIFO_EMPTY_I)
				|| (CTRL_O.irq_half_en && FREE_FIFO_HALF_I);
		end
	end

	// ************************************************************
	// segment FIFO controls
	// ************************************************************
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			SEG_FIFO_RESET_O <= 1'b0;
		end else begin
			SEG_FIFO_RESET_O <= wr_seg_ctrl && REG_WDATA_I[BIT_SEG_FIFO_RESET];
		end
	end

	// flush request stays up until the data path reports all segments returned
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			SEG_FLUSH_O <= 1'b0;
		end else if (soft_rst) begin
			SEG_FLUSH_O <= 1'b0;
		end else if (wr_seg_ctrl && REG_WDATA_I[BIT_SEG_FLUSH]) begin
			SEG_FLUSH_O <= 1'b1;
		end else if (FLUSH_DONE_I) begin
			SEG_FLUSH_O <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			FREE_SEG_WR_O <= 1'b0;
			FREE_SEG_DATA_O <= 32'h0000_0000;
		end else begin
			FREE_SEG_WR_O <= wr_free_seg;
			if (wr_free_seg) begin
				FREE_SEG_DATA_O <= REG_WDATA_I;
			end
		end
	end

	// ************************************************************
	// event parameter port
	// ************************************************************
	// words pair up: first length/source, second event number/seed
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			param_second <= 1'b0;
		end else if (soft_rst) begin
			param_second <= 1'b0;
		end else if (wr_param) begin
			param_second <= !param_second;
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			PARAM_WR_O <= 1'b0;
			PARAM_SECOND_O <= 1'b0;
			PARAM_DATA_O <= 32'h0000_0000;
		end else begin
			PARAM_WR_O <= wr_param;
			if (wr_param) begin
				PARAM_SECOND_O <= param_second;
				PARAM_DATA_O <= REG_WDATA_I;
			end
		end
	end

	// ************************************************************
	// histogram clear
	// ************************************************************
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			HIST_CLEAR_O <= 1'b0;
		end else begin
			HIST_CLEAR_O <= (wr_hist && REG_WDATA_I[BIT_HIST_CLEAR]) || soft_rst;
		end
	end

	// ************************************************************
	// event tally
	// ************************************************************
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			event_tally <= EVENT_TALLY_RESET;
		end else if (soft_rst) begin
			event_tally <= EVENT_TALLY_RESET;
		end else if (EVENT_DONE_I) begin
			event_tally <= event_tally + 64'h0000_0000_0000_0001;
		end
	end

	// ************************************************************
	// byte order of event words
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_swap
			assign swapped[gi*8 +: 8] = EVT_DATA_I[(7-gi)*8 +: 8];
		end
	endgenerate

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			EVT_VALID_O <= 1'b0;
			EVT_DATA_O <= 64'h0000_0000_0000_0000;
		end else begin
			EVT_VALID_O <= EVT_VALID_I && !soft_rst;
			EVT_DATA_O <= CTRL_O.byte_swap ? swapped : EVT_DATA_I;
		end
	end

	// ************************************************************
	// payload generator
	// ************************************************************
	always_comb begin
		next_gen_byte = gen_byte;
		if (GEN_LOAD_I) begin
			next_gen_byte = 8'(GEN_SEED_I * GEN_MULT + GEN_ADD);
		end else if (GEN_STEP_I) begin
			next_gen_byte = 8'(gen_byte * GEN_MULT + GEN_ADD);
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			gen_byte <= 8'h00;
		end else if (soft_rst) begin
			gen_byte <= 8'h00;
		end else begin
			gen_byte <= next_gen_byte;
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			GEN_WORD_O <= 64'h0000_0000_0000_0000;
		end else if (soft_rst) begin
			GEN_WORD_O <= 64'h0000_0000_0000_0000;
		end else begin
			GEN_WORD_O <= {8{next_gen_byte}};
		end
	end

	// ************************************************************
	// read path
	// ************************************************************
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (REG_ADDR_I == OFS_CONTROL_SETUP) begin
			next_rdata[BIT_IRQ_EMPTY_EN] = CTRL_O.irq_empty_en;
			next_rdata[BIT_IRQ_HALF_EN] = CTRL_O.irq_half_en;
			next_rdata[BIT_FIFO_NOT_EMPTY] = !FREE_FIFO_EMPTY_I;
			next_rdata[BIT_FIFO_ABOVE_HALF] = !FREE_FIFO_HALF_I;
			next_rdata[BIT_BYTE_SWAP] = CTRL_O.byte_swap;
			next_rdata[BIT_SLOW_READ] = CTRL_O.slow_read;
			next_rdata[BIT_LINK_EN_LO +: NUM_LINKS] = CTRL_O.link_en;
			next_rdata[BIT_SPY_ALL] = CTRL_O.spy_all;
			next_rdata[BIT_SPY_EN] = CTRL_O.spy_en;
		end else if (REG_ADDR_I == OFS_SEGMENT_FIFO_CONTROL) begin
			next_rdata[BIT_SEG_FLUSH] = SEG_FLUSH_O;
		end else if (REG_ADDR_I == OFS_HISTOGRAM_CONTROL) begin
			next_rdata[BIT_HIST_EN] = CTRL_O.hist_en;
			next_rdata[HIST_GRAN_W-1:0] = CTRL_O.hist_gran;
		end else if (REG_ADDR_I == OFS_CROSSING_NUMBER_LINK0) begin
			next_rdata = CROSSING0_I;
		end else if (REG_ADDR_I == OFS_CROSSING_NUMBER_LINK1) begin
			next_rdata = CROSSING1_I;
		end else if (REG_ADDR_I == OFS_FIRMWARE_REVISION) begin
			next_rdata = FIRMWARE_REVISION_DEFAULT;
		end else if (REG_ADDR_I == OFS_SLOW_READ_LOW && CTRL_O.slow_read) begin
			next_rdata = SLOW_WORD_I.low;
		end else if (REG_ADDR_I == OFS_SLOW_READ_HIGH && CTRL_O.slow_read) begin
			next_rdata = SLOW_WORD_I.high;
		end else if (REG_ADDR_I == OFS_SLOW_READ_CTRL && CTRL_O.slow_read) begin
			next_rdata[0] = SLOW_WORD_I.uctrl;
		end else if (REG_ADDR_I == OFS_EVENT_TALLY_LOW) begin
			next_rdata = event_tally[31:0];
		end else if (REG_ADDR_I == OFS_EVENT_TALLY_HIGH) begin
			next_rdata = event_tally[63:32];
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			REG_RDATA_O <= 32'h0000_0000;
			REG_RVALID_O <= 1'b0;
		end else begin
			REG_RVALID_O <= REG_RD_I;
			if (REG_RD_I) begin
				REG_RDATA_O <= next_rdata;
			end
		end
	end

	// reading the slow-read next register in slow-read mode advances to the next link word
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			SLOW_NEXT_O <= 1'b0;
		end else begin
			SLOW_NEXT_O <= REG_RD_I && CTRL_O.slow_read && REG_ADDR_I == OFS_SLOW_READ_NEXT;
		end
	end

endmodule

/* File: tb/rlc_regs_properties.sv */
// port assertions for the read-out link control register bank
`timescale 1ns/1ps
module rlc_regs_check
	import rlc_pkg::*;
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	// register port and status
	input wire logic [8:0] REG_ADDR_I,
	input wire logic REG_WR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic REG_RD_I,
	input wire logic REG_RVALID_O,
	input wire logic INT_O,
	input wire logic FREE_FIFO_EMPTY_I,
	input wire logic FREE_FIFO_HALF_I,
	input wire logic SEG_FIFO_RESET_O,
	input wire logic SEG_FLUSH_O,
	input wire rlc_ctrl_type CTRL_O,
	input wire logic SOFT_RESET_O,
	input wire logic HIST_CLEAR_O,
	// event path and generator
	input wire logic EVT_VALID_I,
	input wire logic [63:0] EVT_DATA_I,
	input wire logic EVT_VALID_O,
	input wire logic [63:0] EVT_DATA_O,
	input wire logic GEN_LOAD_I,
	input wire logic [7:0] GEN_SEED_I,
	input wire logic GEN_STEP_I,
	input wire logic [63:0] GEN_WORD_O
);
	logic [63:0] swapped;
	logic [7:0] seed_next;
	logic [7:0] step_next;
	logic wr_ctrl;
	assign swapped = {<<8{EVT_DATA_I}};
	assign seed_next = GEN_SEED_I * 8'h05 + 8'h03;
	assign step_next = GEN_WORD_O[7:0] * 8'h05 + 8'h03;
	assign wr_ctrl = REG_WR_I && REG_ADDR_I == OFS_CONTROL_SETUP;

	default clocking @(posedge CLK_I); endclocking
	default disable iff (!ARST_N_I);

	// ************************************************************
	// soft reset steps
	// ************************************************************
	sequence s_soft_write;
		wr_ctrl && REG_WDATA_I[BIT_SOFT_RESET];
	endsequence
	sequence s_soft_outcome;
		SOFT_RESET_O ##1 (CTRL_O == CTRL_RESET && HIST_CLEAR_O && !SEG_FLUSH_O && !INT_O);
	endsequence

	// ************************************************************
	// assertions
	// ************************************************************
	a_soft_reset_steps: assert property (s_soft_write |=> s_soft_outcome)
		else $error("soft reset steps wrong");
	a_read_answer: assert property (REG_RD_I |=> REG_RVALID_O)
		else $error("read not answered in one cycle");
	a_no_stray_valid: assert property (!REG_RD_I |=> !REG_RVALID_O)
		else $error("read valid without read");
	a_irq_level: assert property (!SOFT_RESET_O |=>
		INT_O == $past((CTRL_O.irq_empty_en && FREE_FIFO_EMPTY_I) || (CTRL_O.irq_half_en && FREE_FIFO_HALF_I)))
		else $error("interrupt level wrong");
	a_ctrl_update: assert property (wr_ctrl && !REG_WDATA_I[BIT_SOFT_RESET] && !SOFT_RESET_O |=>
		CTRL_O.link_en == $past(REG_WDATA_I[27:24]) && CTRL_O.byte_swap == $past(REG_WDATA_I[BIT_BYTE_SWAP])
		&& CTRL_O.spy_all == $past(REG_WDATA_I[BIT_SPY_ALL]))
		else $error("control fields not updated");
	a_seg_reset: assert property (REG_WR_I && REG_ADDR_I == OFS_SEGMENT_FIFO_CONTROL
		&& REG_WDATA_I[BIT_SEG_FIFO_RESET] |=> SEG_FIFO_RESET_O)
		else $error("segment fifo reset missing");
	a_flush_start: assert property (REG_WR_I && REG_ADDR_I == OFS_SEGMENT_FIFO_CONTROL
		&& REG_WDATA_I[BIT_SEG_FLUSH] && !SOFT_RESET_O |=> SEG_FLUSH_O)
		else $error("flush not started");
	a_hist_clear: assert property (REG_WR_I && REG_ADDR_I == OFS_HISTOGRAM_CONTROL
		&& REG_WDATA_I[BIT_HIST_CLEAR] |=> HIST_CLEAR_O)
		else $error("histogram clear missing");
	a_swap_path: assert property (EVT_VALID_I && !SOFT_RESET_O |=>
		EVT_VALID_O && EVT_DATA_O == $past(CTRL_O.byte_swap ? swapped : EVT_DATA_I))
		else $error("event word wrong");
	a_gen_load: assert property (GEN_LOAD_I && !SOFT_RESET_O |=> GEN_WORD_O == {8{$past(seed_next)}})
		else $error("generator seed step wrong");
	a_gen_step: assert property (GEN_STEP_I && !GEN_LOAD_I && !SOFT_RESET_O |=>
		GEN_WORD_O == {8{$past(step_next)}})
		else $error("generator next byte wrong");
endmodule

/* File: tb/rlc_far_side.sv */
// model of the free segment fifo seen from the register bank
`timescale 1ns/1ps
module rlc_far_side #(
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic seg_wr_i,
	input wire logic seg_reset_i,
	input wire logic flush_i,
	output logic empty_o,
	output logic half_o,
	output logic flush_done_o
);
	int count;
	assign empty_o = count == 0;
	assign half_o = count <= DEPTH / 2;
	// segments come in from the card writes and go back one per cycle on flush
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count <= 0;
			flush_done_o <= 1'b0;
		end else begin
			flush_done_o <= flush_i && count == 0 && !flush_done_o;
			if (seg_reset_i)
				count <= 0;
			else if (flush_i && count > 0)
				count <= count - 1;
			else if (seg_wr_i && count < DEPTH)
				count <= count + 1;
		end
	end
endmodule

/* File: tb/rlc_regs_bench.sv */
// self-checking bench of the read-out link control register bank
`timescale 1ns/1ps
module rlc_regs_bench;
	import rlc_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [8:0] reg_addr = 9'h000;
	logic reg_wr = 1'b0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_rd = 1'b0;
	logic [31:0] rdata;
	logic rvalid, irq, seg_wr, seg_rst, flush, empty, half, flush_done;
	logic param_wr, param_second, soft_rst, hist_clr, evt_vo, slow_next;
	logic [31:0] seg_data, param_data;
	logic [63:0] evt_do, gen_word;
	rlc_ctrl_type ctrl;
	logic evt_done = 1'b0;
	logic evt_vi = 1'b0;
	logic [63:0] evt_di = 64'h0;
	logic gen_load = 1'b0;
	logic gen_step = 1'b0;
	logic [7:0] gen_seed = 8'h00;
	rlc_slow_word_type slow = '{low: 32'h5A5A_1234, high: 32'h0000_00C3, uctrl: 1'b1};
	int bad_count = 0;
	int check_count = 0;

	initial forever #50 clk = ~clk;

	rlc_regs rlc_regs_inst (.CLK_I(clk), .ARST_N_I(arst_n), .REG_ADDR_I(reg_addr), .REG_WR_I(reg_wr),
		.REG_WDATA_I(reg_wdata), .REG_RD_I(reg_rd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .INT_O(irq),
		.FREE_FIFO_EMPTY_I(empty), .FREE_FIFO_HALF_I(half), .FLUSH_DONE_I(flush_done), .FREE_SEG_WR_O(seg_wr),
		.FREE_SEG_DATA_O(seg_data), .SEG_FIFO_RESET_O(seg_rst), .SEG_FLUSH_O(flush), .PARAM_WR_O(param_wr),
		.PARAM_SECOND_O(param_second), .PARAM_DATA_O(param_data), .CTRL_O(ctrl), .SOFT_RESET_O(soft_rst),
		.HIST_CLEAR_O(hist_clr), .EVENT_DONE_I(evt_done), .EVT_VALID_I(evt_vi), .EVT_DATA_I(evt_di),
		.EVT_VALID_O(evt_vo), .EVT_DATA_O(evt_do), .GEN_LOAD_I(gen_load), .GEN_SEED_I(gen_seed),
		.GEN_STEP_I(gen_step), .GEN_WORD_O(gen_word), .CROSSING0_I(32'h1234_5678), .CROSSING1_I(32'h9ABC_DEF0),
		.SLOW_WORD_I(slow), .SLOW_NEXT_O(slow_next));
	rlc_far_side rlc_far_side_inst (.clk_i(clk), .arst_n_i(arst_n), .seg_wr_i(seg_wr), .seg_reset_i(seg_rst),
		.flush_i(flush), .empty_o(empty), .half_o(half), .flush_done_o(flush_done));

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	task automatic rdc(input logic [8:0] a, input logic [31:0] exp, input string n);
		int k;
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		k = 0;
		while (rvalid !== 1'b1 && k < 4) begin
			@(negedge clk);
			k++;
		end
		if (k == 4) begin
			bad_count++;
			give_verdict();
		end else begin
			chk(n, rdata, exp);
		end
	endtask

	task automatic ticks(input int n);
		repeat (n) @(negedge clk);
	endtask

	initial begin
		ticks(5);
		arst_n = 1'b1;
		// ************************************************************
		// reset values
		// ************************************************************
		rdc(OFS_CONTROL_SETUP, 32'h0, "control");
		rdc(OFS_HISTOGRAM_CONTROL, 32'h1, "histogram");
		rdc(OFS_EVENT_TALLY_HIGH, 32'h0, "tally high");
		rdc(9'h0FC, 32'h0, "unmapped");
		rdc(OFS_FIRMWARE_REVISION, FIRMWARE_REVISION_DEFAULT, "revision");
		$display("reset test done");
		// ************************************************************
		// control, segment fifo and interrupt
		// ************************************************************
		wr(OFS_CONTROL_SETUP, 32'hCF48_0300);
		ticks(2);
		chk("irq empty", irq, 1'b1);
		chk("links", ctrl.link_en, 4'hF);
		chk("spy", {ctrl.spy_en, ctrl.spy_all, ctrl.slow_read}, 3'h7);
		repeat (5) wr(OFS_FREE_SEGMENT_FIFO_PORT, 32'h0010_0000);
		rdc(OFS_CONTROL_SETUP, 32'hCF48_0F00, "control above half");
		chk("irq off", irq, 1'b0);
		wr(OFS_SEGMENT_FIFO_CONTROL, 32'h0004_0000);
		chk("flush on", flush, 1'b1);
		for (int k = 0; k < 20 && flush === 1'b1; k++) ticks(1);
		chk("flush off", {flush, empty}, 2'b01);
		if (flush === 1'b1) begin
			give_verdict();
		end
		repeat (2) wr(OFS_FREE_SEGMENT_FIFO_PORT, 32'h0020_0000);
		chk("segment data", seg_data, 32'h0020_0000);
		rdc(OFS_CONTROL_SETUP, 32'hCF48_0700, "control two held");
		chk("irq half", irq, 1'b1);
		wr(OFS_SEGMENT_FIFO_CONTROL, 32'h0001_0000);
		chk("segment reset", seg_rst, 1'b1);
		rdc(OFS_CONTROL_SETUP, 32'hCF48_0300, "control after fifo reset");
		$display("fifo test done");
		// ************************************************************
		// event tally and byte swap
		// ************************************************************
		@(negedge clk);
		evt_done = 1'b1;
		evt_vi = 1'b1;
		evt_di = 64'h0102_0304_0506_0708;
		@(negedge clk);
		evt_vi = 1'b0;
		chk("swapped valid", evt_vo, 1'b1);
		chk("swapped word", evt_do, 64'h0807_0605_0403_0201);
		ticks(2);
		evt_done = 1'b0;
		wr(OFS_EVENT_TALLY_LOW, 32'hFFFF_FFFF);
		rdc(OFS_EVENT_TALLY_LOW, 32'h3, "tally low");
		rdc(OFS_EVENT_TALLY_HIGH, 32'h0, "tally high");
		$display("event test done");
		// ************************************************************
		// readback, parameters, generator, histogram
		// ************************************************************
		rdc(OFS_CROSSING_NUMBER_LINK0, 32'h1234_5678, "crossing 0");
		rdc(OFS_CROSSING_NUMBER_LINK1, 32'h9ABC_DEF0, "crossing 1");
		rdc(OFS_SLOW_READ_LOW, 32'h5A5A_1234, "slow low");
		rdc(OFS_SLOW_READ_HIGH, 32'h0000_00C3, "slow high");
		rdc(OFS_SLOW_READ_CTRL, 32'h0000_0001, "slow uctrl");
		rdc(OFS_SLOW_READ_NEXT, 32'h0000_0000, "slow next read");
		chk("slow advance", slow_next, 1'b1);
		wr(OFS_EVENT_PARAM_FIFO_PORT, 32'h0A00_0010);
		chk("param first", {param_wr, param_second, param_data}, {2'b10, 32'h0A00_0010});
		wr(OFS_EVENT_PARAM_FIFO_PORT, 32'h1000_0007);
		chk("param second", {param_wr, param_second, param_data}, {2'b11, 32'h1000_0007});
		@(negedge clk);
		gen_load = 1'b1;
		gen_seed = 8'h10;
		@(negedge clk);
		gen_load = 1'b0;
		gen_step = 1'b1;
		chk("gen first", gen_word, {8{8'h53}});
		@(negedge clk);
		gen_step = 1'b0;
		chk("gen next", gen_word, {8{8'hA2}});
		wr(OFS_HISTOGRAM_CONTROL, 32'hC000_0080);
		chk("histogram clear", hist_clr, 1'b1);
		rdc(OFS_HISTOGRAM_CONTROL, 32'h4000_0080, "histogram set");
		$display("readback test done");
		// ************************************************************
		// soft reset
		// ************************************************************
		wr(OFS_CONTROL_SETUP, 32'h0002_0000);
		chk("soft pulse", soft_rst, 1'b1);
		ticks(2);
		rdc(OFS_CONTROL_SETUP, 32'h0, "control after soft reset");
		rdc(OFS_EVENT_TALLY_LOW, 32'h0, "tally after soft reset");
		rdc(OFS_HISTOGRAM_CONTROL, 32'h1, "histogram after soft reset");
		rdc(OFS_SLOW_READ_LOW, 32'h0, "slow low off");
		@(negedge clk);
		evt_vi = 1'b1;
		@(negedge clk);
		evt_vi = 1'b0;
		chk("plain word", evt_do, 64'h0102_0304_0506_0708);
		$display("soft reset test done");
		give_verdict();
	end
endmodule

bind rlc_regs rlc_regs_check rlc_regs_check_inst (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .REG_ADDR_I(REG_ADDR_I),
	.REG_WR_I(REG_WR_I), .REG_WDATA_I(REG_WDATA_I), .REG_RD_I(REG_RD_I), .REG_RVALID_O(REG_RVALID_O),
	.INT_O(INT_O), .FREE_FIFO_EMPTY_I(FREE_FIFO_EMPTY_I), .FREE_FIFO_HALF_I(FREE_FIFO_HALF_I),
	.SEG_FIFO_RESET_O(SEG_FIFO_RESET_O), .SEG_FLUSH_O(SEG_FLUSH_O), .CTRL_O(CTRL_O), .SOFT_RESET_O(SOFT_RESET_O),
	.HIST_CLEAR_O(HIST_CLEAR_O), .EVT_VALID_I(EVT_VALID_I), .EVT_DATA_I(EVT_DATA_I), .EVT_VALID_O(EVT_VALID_O),
	.EVT_DATA_O(EVT_DATA_O), .GEN_LOAD_I(GEN_LOAD_I), .GEN_SEED_I(GEN_SEED_I), .GEN_STEP_I(GEN_STEP_I),
	.GEN_WORD_O(GEN_WORD_O));
